// ### hw/tlc_cfg.svh
// tlc_cfg.svh: offsets, field widths, reset values and timing counts
// for the lane control register block; included by its bare name.
`ifndef TLC_CFG_SVH
`define TLC_CFG_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define TLC_OFS_SEL_B1 12'h400
`define TLC_OFS_POST 12'h414
`define TLC_OFS_PRE 12'h418
`define TLC_OFS_LOOP 12'h41c
`define TLC_OFS_SEL_B2 12'h500
`define TLC_OFS_PWR 12'h504
`define TLC_OFS_SWING 12'h508
`define TLC_OFS_BLOCK 12'h50c
`define TLC_OFS_TXINV 12'h510
`define TLC_OFS_SEL_B3 12'h600
`define TLC_OFS_RXINV 12'h604
`define TLC_OFS_MB_SEL 12'h200
`define TLC_OFS_MB_ADDR 12'h204
`define TLC_OFS_MB_WDATA 12'h208
`define TLC_OFS_MB_RDATA 12'h20c
`define TLC_OFS_MB_STAT 12'h214

// ****************************************
// field positions and widths
// ****************************************
`define TLC_W_EMPH 5
`define TLC_W_LOOP 3
`define TLC_W_PWR 2
`define TLC_W_SWING 4
`define TLC_W_SEL 8
`define TLC_BIT_MB_WR 31
`define TLC_BIT_MB_RD 30
`define TLC_W_CFG_DATA 16

// ****************************************
// reset values
// ****************************************
`define TLC_RST_SEL 8'h00
`define TLC_RST_MB_ADDR 32'h0000_0000
`define TLC_RST_MB_DATA 16'h0000

// ****************************************
// loopback codes, power states
// ****************************************
`define TLC_LOOP_NORMAL 3'h0
`define TLC_LOOP_NE_PCS 3'h1
`define TLC_LOOP_NE_PMA 3'h2
`define TLC_LOOP_FE_PMA 3'h4
`define TLC_LOOP_FE_PCS 3'h6
`define TLC_PWR_NORMAL 2'h0
`define TLC_PWR_LOWEST 2'h3
`define TLC_PRE_SATURATE 5'h14

// ****************************************
// config-port divider fields and encodings
// ****************************************
`define TLC_CFG_TXOUT_ADDR 16'h007c
`define TLC_CFG_TXOUT_MSB 10
`define TLC_CFG_TXOUT_LSB 8
`define TLC_CFG_RXOUT_ADDR 16'h0063
`define TLC_CFG_RXOUT_MSB 2
`define TLC_CFG_RXOUT_LSB 0
`define TLC_CFG_PLLA_FB_ADDR 16'h0014
`define TLC_CFG_PLLB_FB_ADDR 16'h0094
`define TLC_CFG_PLLA_REF_ADDR 16'h0018
`define TLC_CFG_PLLB_REF_ADDR 16'h0098
`define TLC_CFG_REF_MSB 11
`define TLC_CFG_REF_LSB 7
`define TLC_CFG_REF_DIV1_CODE 5'h10
`define TLC_CFG_FB_OFFSET 8'h02

// ****************************************
// timing counts
// ****************************************
`define TLC_BANK_WAIT 3'h3
`define TLC_PLAIN_WAIT 3'h0

`endif

// ### hw/tlc_pkg.sv
// tlc_pkg: types shared by the lane control register block.
// assumes tlc_cfg.svh is on the include path.
package tlc_pkg;
  typedef logic [11:0] tlc_addr_t;
  typedef logic [31:0] tlc_word_t;
  typedef logic [7:0] tlc_sel_t;
  typedef enum logic [0:0] {
    TLC_IDLE = 1'b0,
    TLC_WAIT = 1'b1
  } tlc_state_t;
endpackage

// ### hw/tlc_lane_bank.sv
// tlc_lane_bank: one control field held separately for every lane.
// assumes writes arrive as one-cycle strobes on the same clock.
`timescale 1ns/1ps
`default_nettype none
module tlc_lane_bank #(
  parameter int NLANES = 4,
  parameter int W = 5
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // write strobe, lane index, data
  input wire logic i_we,
  input wire logic [7:0] i_idx,
  input wire logic [W-1:0] i_wdata,
  // per-lane values and selected lane readback
  output logic [NLANES*W-1:0] o_vec,
  output logic [W-1:0] o_sel_val
);
  import tlc_pkg::*;

  // ****************************************
  // per-lane storage
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < NLANES; g++) begin : g_lane
      logic [W-1:0] val_r;
      wire hit = i_we && (i_idx == 8'(g));
      // only the indexed lane takes the write
      always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
          val_r <= '0;
        end else if (hit) begin
          val_r <= i_wdata;
        end
      end
      assign o_vec[g*W +: W] = val_r;
    end
  endgenerate

  // selected lane readback, zero when index is out of range
  assign o_sel_val = (i_idx < 8'(NLANES)) ? o_vec[i_idx*W +: W] : '0;
endmodule
`default_nettype wire

// ### hw/tlc_cfg_mbox.sv
// tlc_cfg_mbox: mailbox into the lanes' dynamic config port.
// assumes the config port runs on i_mclk and answers with a ready pulse.
`timescale 1ns/1ps
`default_nettype none
`include "tlc_cfg.svh"
module tlc_cfg_mbox #(
  parameter int CFG_AW = 10
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // register writes from the bus side
  input wire logic i_we_sel,
  input wire logic i_we_addr,
  input wire logic i_we_data,
  input wire tlc_pkg::tlc_word_t i_wdata,
  // register readback
  output tlc_pkg::tlc_sel_t o_sel,
  output tlc_pkg::tlc_word_t o_addr_word,
  output logic [15:0] o_wdata,
  output logic [15:0] o_rdata,
  output logic o_busy,
  output logic o_is_write,
  // config port
  output logic o_cfg_en,
  output logic o_cfg_we,
  output logic [CFG_AW-1:0] o_cfg_addr,
  output logic [15:0] o_cfg_wdata,
  output tlc_pkg::tlc_sel_t o_cfg_lane,
  input wire logic i_cfg_rdy,
  input wire logic [15:0] i_cfg_rdata
);
  import tlc_pkg::*;

  logic [29:0] addr_r;
  logic [1:0] flag_r;
  logic en_r;
  logic busy_r;
  logic type_r;
  logic [15:0] wd_r;
  logic [15:0] rd_r;
  tlc_sel_t sel_r;

  // ****************************************
  // start decode
  // ****************************************
  wire want_wr = i_wdata[`TLC_BIT_MB_WR];
  wire want_rd = i_wdata[`TLC_BIT_MB_RD];
  wire start = i_we_addr && (want_wr ^ want_rd) && !busy_r;
  wire [1:0] flag_nxt = (want_wr && want_rd) ? 2'h0 : {want_wr, want_rd};

  // address, data and select registers
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      addr_r <= 30'h0;
      flag_r <= 2'h0;
      wd_r <= `TLC_RST_MB_DATA;
      sel_r <= `TLC_RST_SEL;
    end else begin
      if (i_we_addr) begin
        addr_r <= i_wdata[29:0];
        flag_r <= flag_nxt; // both set reads back as zero
      end
      if (i_we_data) begin
        wd_r <= i_wdata[15:0];
      end
      if (i_we_sel) begin
        sel_r <= i_wdata[7:0];
      end
    end
  end

  // access sequencing: strobe once, busy until the port answers
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      en_r <= 1'b0;
      busy_r <= 1'b0;
      type_r <= 1'b0;
      rd_r <= `TLC_RST_MB_DATA;
    end else begin
      en_r <= start;
      if (start) begin
        busy_r <= 1'b1;
        type_r <= want_wr;
      end else if (busy_r && i_cfg_rdy && !en_r) begin
        busy_r <= 1'b0;
        if (!type_r) begin
          rd_r <= i_cfg_rdata;
        end
      end
    end
  end

  assign o_sel = sel_r;
  assign o_addr_word = {flag_r, addr_r};
  assign o_wdata = wd_r;
  assign o_rdata = rd_r;
  assign o_busy = busy_r;
  assign o_is_write = type_r;
  assign o_cfg_en = en_r;
  assign o_cfg_we = en_r && type_r;
  assign o_cfg_addr = addr_r[CFG_AW-1:0]; // full port address reach
  assign o_cfg_wdata = wd_r;
  assign o_cfg_lane = sel_r;

  // ****************************************
  // checks
  // ****************************************
  AST_MB_WR_START: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_we_addr && want_wr && !want_rd && !busy_r) |=> (o_cfg_en && o_cfg_we && o_busy))
    else $error("config write did not start");
  AST_MB_BOTH_IGNORED: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_we_addr && want_wr && want_rd) |=> (!o_cfg_en && o_addr_word[31:30] == 2'h0))
    else $error("dual flag access was not ignored");
  AST_MB_DONE: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (busy_r && !en_r && i_cfg_rdy && !type_r) |=> (!o_busy && o_rdata == $past(i_cfg_rdata)))
    else $error("config read data not captured");
endmodule
`default_nettype wire

// ### hw/tlc_regs.sv
// tlc_regs: per-lane transceiver control register bank with config mailbox.
// assumes a single-clock register port: one-cycle read or write strobes,
// answered later by a one-cycle acknowledge carrying the read data.
//
// Notes on behaviour
// - loopback code per lane: 000 normal, 001/010 near-end, 100/110 far-end.
// - bank two and three selects hold an eight-bit lane index.
// - two-bit transmit power state held per lane, written to the bank two selected lane; 00 normal, 11 lowest.
// - four-bit swing code forwarded per lane, resets to zero.
// - five-bit post-emphasis held per lane, resets to zero, forwarded.
// - five-bit pre-emphasis forwarded; codes twenty and up saturate downstream.
// - output block bit forwarded so the lane silences its serial output.
// - transmit invert bit forwarded to flip outgoing polarity.
// - receive invert bit forwarded to flip incoming polarity.
// - mailbox reaches every config port address.
// - output dividers at 007C[10:8] and 0063[2:0], ratios coded 0 to 4.
// - feedback divider coded ratio minus two; reference ratio 1 coded 16.
// - three banks with own selects; bank accesses take longer to finish.
// - address bit 31 starts write, bit 30 read, both set ignored.
`timescale 1ns/1ps
`default_nettype none
`include "tlc_cfg.svh"
module tlc_regs #(
  parameter int NLANES = 4,
  parameter int CFG_AW = 10
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // register port
  input wire logic i_wr,
  input wire logic i_rd,
  input wire tlc_pkg::tlc_addr_t i_addr,
  input wire tlc_pkg::tlc_word_t i_wdata,
  output tlc_pkg::tlc_word_t o_rdata,
  output logic o_ack,
  output logic o_busy,
  // per-lane controls, lane n in slice n
  output logic [NLANES*5-1:0] o_tx_post_emphasis,
  output logic [NLANES*5-1:0] o_tx_pre_emphasis,
  output logic [NLANES*3-1:0] o_loopback,
  output logic [NLANES*2-1:0] o_tx_power_state,
  output logic [NLANES*4-1:0] o_tx_swing_code,
  output logic [NLANES-1:0] o_tx_output_block,
  output logic [NLANES-1:0] o_tx_invert,
  output logic [NLANES-1:0] o_rx_invert,
  // dynamic config port
  output logic o_cfg_en,
  output logic o_cfg_we,
  output logic [CFG_AW-1:0] o_cfg_addr,
  output logic [15:0] o_cfg_wdata,
  output tlc_pkg::tlc_sel_t o_cfg_lane,
  input wire logic i_cfg_rdy,
  input wire logic [15:0] i_cfg_rdata
);
  import tlc_pkg::*;

  // ****************************************
  // request tracking
  // ****************************************
  tlc_state_t state_r;
  tlc_state_t state_nxt;
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic pend_wr_r;
  tlc_addr_t pend_addr_r;
  tlc_word_t pend_wdata_r;
  logic ack_r;
  tlc_word_t rdata_r;
  tlc_sel_t sel_b1_r;
  tlc_sel_t sel_b2_r;
  tlc_sel_t sel_b3_r;

  // bank registers sit in the slow group
  wire in_bank = (i_addr >= `TLC_OFS_SEL_B1 && i_addr <= `TLC_OFS_LOOP) ||
                 (i_addr >= `TLC_OFS_SEL_B2 && i_addr <= `TLC_OFS_TXINV) ||
                 (i_addr == `TLC_OFS_SEL_B3) || (i_addr == `TLC_OFS_RXINV);
  wire idle = (state_r == TLC_IDLE);
  wire accept = idle && (i_wr || i_rd);
  wire done = (state_r == TLC_WAIT) && (cnt_r == 3'h0);
  wire do_wr = done && pend_wr_r;

  // next state and wait count
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      TLC_IDLE: begin
        if (accept) begin
          state_nxt = TLC_WAIT;
          cnt_nxt = in_bank ? `TLC_BANK_WAIT : `TLC_PLAIN_WAIT;
        end
      end
      TLC_WAIT: begin
        if (cnt_r == 3'h0) begin
          state_nxt = TLC_IDLE;
        end else begin
          cnt_nxt = cnt_r - 3'h1;
        end
      end
      default: begin
        state_nxt = TLC_IDLE;
      end
    endcase
  end

  // request state registers
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_r <= TLC_IDLE;
      cnt_r <= 3'h0;
      ack_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      ack_r <= done;
    end
  end

  // capture of the accepted request; write wins over read
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      pend_wr_r <= 1'b0;
      pend_addr_r <= 12'h000;
      pend_wdata_r <= 32'h0000_0000;
    end else if (accept) begin
      pend_wr_r <= i_wr;
      pend_addr_r <= i_addr;
      pend_wdata_r <= i_wdata;
    end
  end

  // ****************************************
  // write decode
  // ****************************************
  wire wr_sel1 = do_wr && (pend_addr_r == `TLC_OFS_SEL_B1);
  wire wr_sel2 = do_wr && (pend_addr_r == `TLC_OFS_SEL_B2);
  wire wr_sel3 = do_wr && (pend_addr_r == `TLC_OFS_SEL_B3);
  wire wr_post = do_wr && (pend_addr_r == `TLC_OFS_POST);
  wire wr_pre = do_wr && (pend_addr_r == `TLC_OFS_PRE);
  wire wr_loop = do_wr && (pend_addr_r == `TLC_OFS_LOOP);
  wire wr_pwr = do_wr && (pend_addr_r == `TLC_OFS_PWR);
  wire wr_swing = do_wr && (pend_addr_r == `TLC_OFS_SWING);
  wire wr_block = do_wr && (pend_addr_r == `TLC_OFS_BLOCK);
  wire wr_txinv = do_wr && (pend_addr_r == `TLC_OFS_TXINV);
  wire wr_rxinv = do_wr && (pend_addr_r == `TLC_OFS_RXINV);
  wire wr_mb_sel = do_wr && (pend_addr_r == `TLC_OFS_MB_SEL);
  wire wr_mb_addr = do_wr && (pend_addr_r == `TLC_OFS_MB_ADDR);
  wire wr_mb_data = do_wr && (pend_addr_r == `TLC_OFS_MB_WDATA);

  // bank select registers
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      sel_b1_r <= `TLC_RST_SEL;
      sel_b2_r <= `TLC_RST_SEL;
      sel_b3_r <= `TLC_RST_SEL;
    end else begin
      if (wr_sel1) sel_b1_r <= pend_wdata_r[7:0];
      if (wr_sel2) sel_b2_r <= pend_wdata_r[7:0];
      if (wr_sel3) sel_b3_r <= pend_wdata_r[7:0];
    end
  end

  // ****************************************
  // per-lane field banks
  // ****************************************
  logic [4:0] post_sel;
  logic [4:0] pre_sel;
  logic [2:0] loop_sel;
  logic [1:0] pwr_sel;
  logic [3:0] swing_sel;
  logic block_sel;
  logic txinv_sel;
  logic rxinv_sel;

  // bank one: emphasis and loopback
  tlc_lane_bank #(.NLANES(NLANES), .W(`TLC_W_EMPH)) u_post (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_we(wr_post), .i_idx(sel_b1_r),
    .i_wdata(pend_wdata_r[4:0]), .o_vec(o_tx_post_emphasis), .o_sel_val(post_sel));
  tlc_lane_bank #(.NLANES(NLANES), .W(`TLC_W_EMPH)) u_pre (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_we(wr_pre), .i_idx(sel_b1_r),
    .i_wdata(pend_wdata_r[4:0]), .o_vec(o_tx_pre_emphasis), .o_sel_val(pre_sel));
  tlc_lane_bank #(.NLANES(NLANES), .W(`TLC_W_LOOP)) u_loop (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_we(wr_loop), .i_idx(sel_b1_r),
    .i_wdata(pend_wdata_r[2:0]), .o_vec(o_loopback), .o_sel_val(loop_sel));

  // bank two: power, swing, block, transmit invert
  tlc_lane_bank #(.NLANES(NLANES), .W(`TLC_W_PWR)) u_pwr (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_we(wr_pwr), .i_idx(sel_b2_r),
    .i_wdata(pend_wdata_r[1:0]), .o_vec(o_tx_power_state), .o_sel_val(pwr_sel));
  tlc_lane_bank #(.NLANES(NLANES), .W(`TLC_W_SWING)) u_swing (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_we(wr_swing), .i_idx(sel_b2_r),
    .i_wdata(pend_wdata_r[3:0]), .o_vec(o_tx_swing_code), .o_sel_val(swing_sel));
  tlc_lane_bank #(.NLANES(NLANES), .W(1)) u_block (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_we(wr_block), .i_idx(sel_b2_r),
    .i_wdata(pend_wdata_r[0]), .o_vec(o_tx_output_block), .o_sel_val(block_sel));
  tlc_lane_bank #(.NLANES(NLANES), .W(1)) u_txinv (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_we(wr_txinv), .i_idx(sel_b2_r),
    .i_wdata(pend_wdata_r[0]), .o_vec(o_tx_invert), .o_sel_val(txinv_sel));

  // bank three: receive invert
  tlc_lane_bank #(.NLANES(NLANES), .W(1)) u_rxinv (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_we(wr_rxinv), .i_idx(sel_b3_r),
    .i_wdata(pend_wdata_r[0]), .o_vec(o_rx_invert), .o_sel_val(rxinv_sel));

  // ****************************************
  // config mailbox
  // ****************************************
  tlc_sel_t mb_sel;
  tlc_word_t mb_addr_word;
  logic [15:0] mb_wdata;
  logic [15:0] mb_rdata;
  logic mb_busy;
  logic mb_is_write;

  // config port access
  tlc_cfg_mbox #(.CFG_AW(CFG_AW)) u_mbox (
    .i_mclk(i_mclk), .i_nrst(i_nrst),
    .i_we_sel(wr_mb_sel), .i_we_addr(wr_mb_addr), .i_we_data(wr_mb_data),
    .i_wdata(pend_wdata_r),
    .o_sel(mb_sel), .o_addr_word(mb_addr_word), .o_wdata(mb_wdata),
    .o_rdata(mb_rdata), .o_busy(mb_busy), .o_is_write(mb_is_write),
    .o_cfg_en(o_cfg_en), .o_cfg_we(o_cfg_we), .o_cfg_addr(o_cfg_addr),
    .o_cfg_wdata(o_cfg_wdata), .o_cfg_lane(o_cfg_lane),
    .i_cfg_rdy(i_cfg_rdy), .i_cfg_rdata(i_cfg_rdata));

  // ****************************************
  // read mux
  // ****************************************
  wire [31:0] mb_stat = {29'h0, mb_busy && mb_is_write, 1'b0, mb_busy};
  // selected lane values, upper bits zero, unmapped reads zero
  wire [31:0] rd_mux =
    (pend_addr_r == `TLC_OFS_SEL_B1) ? {24'h0, sel_b1_r} :
    (pend_addr_r == `TLC_OFS_POST) ? {27'h0, post_sel} :
    (pend_addr_r == `TLC_OFS_PRE) ? {27'h0, pre_sel} :
    (pend_addr_r == `TLC_OFS_LOOP) ? {29'h0, loop_sel} :
    (pend_addr_r == `TLC_OFS_SEL_B2) ? {24'h0, sel_b2_r} :
    (pend_addr_r == `TLC_OFS_PWR) ? {30'h0, pwr_sel} :
    (pend_addr_r == `TLC_OFS_SWING) ? {28'h0, swing_sel} :
    (pend_addr_r == `TLC_OFS_BLOCK) ? {31'h0, block_sel} :
    (pend_addr_r == `TLC_OFS_TXINV) ? {31'h0, txinv_sel} :
    (pend_addr_r == `TLC_OFS_SEL_B3) ? {24'h0, sel_b3_r} :
    (pend_addr_r == `TLC_OFS_RXINV) ? {31'h0, rxinv_sel} :
    (pend_addr_r == `TLC_OFS_MB_SEL) ? {24'h0, mb_sel} :
    (pend_addr_r == `TLC_OFS_MB_ADDR) ? mb_addr_word :
    (pend_addr_r == `TLC_OFS_MB_WDATA) ? {16'h0, mb_wdata} :
    (pend_addr_r == `TLC_OFS_MB_RDATA) ? {16'h0, mb_rdata} :
    (pend_addr_r == `TLC_OFS_MB_STAT) ? mb_stat : 32'h0000_0000;

  // read data register, loaded at completion of a read
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_r <= 32'h0000_0000;
    end else if (done && !pend_wr_r) begin
      rdata_r <= rd_mux;
    end
  end

  assign o_rdata = rdata_r;
  assign o_ack = ack_r;
  assign o_busy = !idle;

  // ****************************************
  // checks
  // ****************************************
  sequence s_bank_req;
    accept && in_bank;
  endsequence
  sequence s_bank_wait;
    (!o_ack) [*4] ##1 o_ack;
  endsequence
  wire [NLANES*5-1:0] post_mask = {{(NLANES-1)*5{1'b0}}, 5'h1f} << (sel_b1_r * 5);

  AST_BANK_LATENCY: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    s_bank_req |=> s_bank_wait)
    else $error("bank access ack not after five cycles");
  AST_PLAIN_LATENCY: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (accept && !in_bank) |=> !o_ack ##1 o_ack)
    else $error("plain access ack not after two cycles");
  AST_LOOP_APPLIED: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (wr_loop && sel_b1_r < 8'(NLANES)) |=> (loop_sel == $past(pend_wdata_r[2:0])))
    else $error("loopback code not applied to selected lane");
  AST_OTHER_LANES_KEPT: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    wr_post |=> (((o_tx_post_emphasis ^ $past(o_tx_post_emphasis)) &
      ~$past(post_mask)) == '0))
    else $error("post-emphasis write disturbed another lane");
  AST_SWING_READBACK: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (done && !pend_wr_r && pend_addr_r == `TLC_OFS_SWING) |=>
      (o_ack && o_rdata == {28'h0, $past(swing_sel)}))
    else $error("swing readback wrong");
  AST_UNMAPPED_ZERO: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (done && !pend_wr_r && pend_addr_r == 12'h7f0) |=> o_rdata == 32'h0)
    else $error("unmapped read not zero");
  AST_PWR_SEL_LANE: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (wr_pwr && sel_b2_r < 8'(NLANES)) |=> (pwr_sel == $past(pend_wdata_r[1:0])))
    else $error("power state not applied to selected lane");
  AST_PWR_HELD: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    !(wr_pwr || wr_sel2) |=> $stable(pwr_sel))
    else $error("power state changed without a write");
endmodule
`default_nettype wire

// ### test/tlc_cfg_port_model.sv
// tlc_cfg_port_model: far-side config port of the lanes.
// assumes strobes arrive on the same clock as the register block.
`timescale 1ns/1ps
`default_nettype none
module tlc_cfg_port_model (
  // clock and strobe
  input wire logic i_mclk,
  input wire logic i_en,
  input wire logic i_we,
  input wire logic [9:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic [3:0] i_lag,
  // answer
  output logic o_rdy,
  output logic [15:0] o_rdata
);
  logic [15:0] mem [1024];
  logic [9:0] a;
  logic [3:0] cnt = 4'h0;
  int n_str = 0;
  // port starts with a cleared map
  initial begin
    o_rdy = 1'b0;
    o_rdata = 16'h0;
    foreach (mem[k]) mem[k] = 16'h0;
  end
  // answer i_lag+1 cycles after a strobe
  always @(posedge i_mclk) begin
    o_rdy <= 1'b0;
    o_rdata <= ~o_rdata;  // stale data never holds
    if (cnt != 4'h0) cnt <= cnt - 4'h1;
    if (cnt == 4'h1) begin
      o_rdy <= 1'b1;
      o_rdata <= mem[a];
    end
    if (i_en) begin
      n_str <= n_str + 1;
      a <= i_addr;
      cnt <= i_lag + 4'h1;
      if (i_we) mem[i_addr] <= i_wdata;
    end
  end
endmodule
`default_nettype wire

// ### test/tb_top.sv
// tb_top: self-checking bench for the lane control registers.
// assumes tlc_cfg.svh on the include path, NLANES of 4.
`timescale 1ns/1ps
`default_nettype none
`include "tlc_cfg.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  import tlc_pkg::*;
  // ****************************************
  // design, far side, clock
  // ****************************************
  logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, rdy, ack, busy, cen, cwe;
  tlc_addr_t addr = '0;
  tlc_word_t wd = '0, rq, q;
  logic [19:0] post, pre;
  logic [11:0] loop;
  logic [7:0] pwr;
  logic [15:0] swing, cwd, crd;
  logic [3:0] blk, tinv, rinv, lag = 4'h1;
  logic [9:0] cad;
  tlc_sel_t clane;
  logic [31:0] seed = 32'h5a0a;
  logic [4:0] m [8][4];
  logic [4:0] lbc [5] = '{5'h0, 5'h1, 5'h2, 5'h4, 5'h6};
  int failures = 0, n_compared = 0, cyc = 0, lat, ns;
  tlc_addr_t ofs [8] = '{`TLC_OFS_POST, `TLC_OFS_PRE, `TLC_OFS_LOOP, `TLC_OFS_PWR,
    `TLC_OFS_SWING, `TLC_OFS_BLOCK, `TLC_OFS_TXINV, `TLC_OFS_RXINV};
  int wid [8] = '{5, 5, 3, 2, 4, 1, 1, 1};
  // free-running clock
  always #50 clk = ~clk;
  tlc_regs dut (.i_mclk(clk), .i_nrst(nrst), .i_wr(wr), .i_rd(rd), .i_addr(addr),
    .i_wdata(wd), .o_rdata(rq), .o_ack(ack), .o_busy(busy), .o_tx_post_emphasis(post),
    .o_tx_pre_emphasis(pre), .o_loopback(loop), .o_tx_power_state(pwr),
    .o_tx_swing_code(swing), .o_tx_output_block(blk), .o_tx_invert(tinv),
    .o_rx_invert(rinv), .o_cfg_en(cen), .o_cfg_we(cwe), .o_cfg_addr(cad),
    .o_cfg_wdata(cwd), .o_cfg_lane(clane), .i_cfg_rdy(rdy), .i_cfg_rdata(crd));
  tlc_cfg_port_model pm (.i_mclk(clk), .i_en(cen), .i_we(cwe), .i_addr(cad),
    .i_wdata(cwd), .i_lag(lag), .o_rdy(rdy), .o_rdata(crd));
  // xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // bank select register of a field
  function automatic tlc_addr_t bsel(int f);
    return f < 3 ? `TLC_OFS_SEL_B1 : f < 7 ? `TLC_OFS_SEL_B2 : `TLC_OFS_SEL_B3;
  endfunction
  // lane l's slice of field f
  function automatic logic [4:0] outv(int f, int l);
    logic [4:0] v [8];
    v = '{post[l*5+:5], pre[l*5+:5], 5'(loop[l*3+:3]), 5'(pwr[l*2+:2]),
      5'(swing[l*4+:4]), 5'(blk[l]), 5'(tinv[l]), 5'(rinv[l])};
    return v[f];
  endfunction
  // one bus access, answer taken in the ack cycle
  task automatic acc(input logic w, input tlc_addr_t a, input tlc_word_t d);
    wr = w;
    rd = !w;
    addr = a;
    wd = d;
    @(posedge clk);
    #1;
    wr = 1'b0;
    rd = 1'b0;
    `CHK(busy, 1'b1)
    lat = 1;
    while (ack !== 1'b1 && lat < 20) begin
      @(posedge clk);
      #1;
      lat++;
    end
    if (ack !== 1'b1) failures++;
    q = rq;
  endtask
  task automatic rdx(input tlc_addr_t a, input tlc_word_t e);
    acc(1'b0, a, '0);
    `CHK(q, e)
  endtask
  // select lane, write field with junk above it, check all lanes
  task automatic setf(input int f, input int l, input logic [4:0] v);
    v = v & 5'((1 << wid[f]) - 1);
    acc(1'b1, bsel(f), 32'(l));
    acc(1'b1, ofs[f], (rnd() << wid[f]) | 32'(v));
    if (l < 4) m[f][l] = v;
    rdx(ofs[f], l < 4 ? 32'(v) : 32'h0);
    for (int k = 0; k < 4; k++) `CHK(outv(f, k), m[f][k])
  endtask
  // start a port access, poll until idle
  task automatic mbx(input logic [31:0] cmd);
    acc(1'b1, `TLC_OFS_MB_ADDR, cmd);
    q = '1;
    for (int k = 0; k < 30 && q[0] !== 1'b0; k++) acc(1'b0, `TLC_OFS_MB_STAT, '0);
    `CHK(q[0], 1'b0)
  endtask
  task automatic wrap_up();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      wrap_up();
    end
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (6) @(posedge clk);
    #1;
    nrst = 1'b1;
    foreach (m[f, l]) begin
      m[f][l] = 5'h0;
      `CHK(outv(f, l), 5'h0)
    end
    foreach (ofs[f]) rdx(ofs[f], 32'h0);
    `CHK(lat, 5)
    rdx(12'h7f0, 32'h0);
    `CHK(lat, 2)
    foreach (lbc[i]) setf(2, 3, lbc[i]);
    setf(3, 1, 5'h3);
    setf(3, 1, 5'h0);
    setf(4, 2, 5'hf);
    setf(0, 1, 5'h1f);
    setf(1, 0, 5'h14);
    setf(1, 0, 5'h1f);
    setf(5, 3, 5'h1);
    setf(6, 2, 5'h1);
    setf(7, 1, 5'h1);
    setf(0, 4, 5'h1f);
    rdx(`TLC_OFS_SEL_B1, 32'h4);
    repeat (60) setf(rnd() % 8, rnd() % 4, 5'(rnd()));
    // traffic idle, then dividers rewritten over the port
    acc(1'b1, `TLC_OFS_MB_SEL, 32'h2);
    pm.mem[10'h07c] = 16'hffff;
    mbx(32'h4000_007c);
    rdx(`TLC_OFS_MB_RDATA, 32'h0000_ffff);
    acc(1'b1, `TLC_OFS_MB_WDATA, (q & ~32'h700) | (32'($clog2(4)) << 8));
    rdx(`TLC_OFS_MB_WDATA, 32'h0000_faff);
    lag = 4'h9;
    mbx(32'h8000_007c);
    `CHK(pm.mem[10'h07c], 16'hfaff)
    `CHK(clane, 8'h2)
    acc(1'b1, `TLC_OFS_MB_WDATA, 32'(66 - 2));
    mbx(32'h8000_0094);
    `CHK(pm.mem[10'h094], 16'd64)
    acc(1'b1, `TLC_OFS_MB_WDATA, 32'(16) << 7);
    mbx(32'h8000_0098);
    `CHK(pm.mem[10'h098], 16'h0800)
    ns = pm.n_str;
    acc(1'b1, `TLC_OFS_MB_ADDR, 32'hc000_0014);
    rdx(`TLC_OFS_MB_ADDR, 32'h0000_0014);
    `CHK(pm.n_str, ns)
    wrap_up();
  end
endmodule
`default_nettype wire
